// ==== hw/ipb_pkg.sv ====
// Package of offsets, field positions and reset values for the priority bank
package ipb_pkg;

   // ==========================================================
   // Register byte offsets (word aligned on the AXI4-Lite bus)
   localparam logic [4:0] OFS_T2_OC2_IC2   = 5'h00;
   localparam logic [4:0] OFS_RX1_SPI1_T3  = 5'h04;
   localparam logic [4:0] OFS_AD_TX1       = 5'h08;
   localparam logic [4:0] OFS_CN_CM_I2C1   = 5'h0c;
   localparam logic [4:0] OFS_EXT1         = 5'h10;
   localparam logic [4:0] OFS_T4_OC4_OC3   = 5'h14;
   localparam logic [4:0] OFS_TX2_EXT2_T5  = 5'h18;
   localparam logic [4:0] OFS_SPI2         = 5'h1c;

   // ==========================================================
   // Field positions (low bit of each 3-bit field)
   localparam int POS_HI  = 12;
   localparam int POS_MH  = 8;
   localparam int POS_ML  = 4;
   localparam int POS_LO  = 0;
   localparam int PRIO_W  = 3;

   // ==========================================================
   // Reset value of every priority field, and source count
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam int         NUM_SRC    = 24;

   // AXI4-Lite response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ipb_pkg

// ==== hw/ipb_field.sv ====
// One 3-bit priority field with reset value and write strobe
`timescale 1ns/1ps
module ipb_field
   import ipb_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [2:0]       wr_data,
   // Field value
   output logic      [2:0]       value
);

   // ==========================================================
   // Storage
   logic [2:0] value_reg;

   // Field loads on a strobed write and holds otherwise
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         value_reg <= PRIO_RESET;
      else if (wr_en)
         value_reg <= wr_data;
   end

   assign value = value_reg;

endmodule : ipb_field

// ==== hw/ipb_bank.sv ====
// Interrupt priority bank: AXI4-Lite slave holding 3-bit source priorities
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module ipb_bank
   import ipb_pkg::*;
(
   // Clock and reset
   input  wire logic                  CORE_CLK,
   input  wire logic                  RESET_N,
   // AXI4-Lite write address
   input  wire logic [4:0]            S_AXI_AWADDR,
   input  wire logic                  S_AXI_AWVALID,
   output logic                       S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire logic [31:0]           S_AXI_WDATA,
   input  wire logic [3:0]            S_AXI_WSTRB,
   input  wire logic                  S_AXI_WVALID,
   output logic                       S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0]                 S_AXI_BRESP,
   output logic                       S_AXI_BVALID,
   input  wire logic                  S_AXI_BREADY,
   // AXI4-Lite read address
   input  wire logic [4:0]            S_AXI_ARADDR,
   input  wire logic                  S_AXI_ARVALID,
   output logic                       S_AXI_ARREADY,
   // AXI4-Lite read data
   output logic [31:0]                S_AXI_RDATA,
   output logic [1:0]                 S_AXI_RRESP,
   output logic                       S_AXI_RVALID,
   input  wire logic                  S_AXI_RREADY,
   // Priorities to the arbiter, source i in bits 3i+2:3i
   output logic [NUM_SRC*PRIO_W-1:0]  PRIO_LEVELS,
   // High where a mapped source's priority is non-zero
   output logic [NUM_SRC-1:0]         SRC_ACTIVE
);

   import ipb_pkg::*;

   // ==========================================================
   // Reset release through two flip-flops
   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // ==========================================================
   // Field map: register index and bit position of every source
   // Order: T2,OC2,IC2 | RX1,SPI1,SPF1,T3 | AD,TX1 | CN,CM,MI2C1,SI2C1 |
   //        EXT1 | T4,OC4,OC3 | TX2,RX2,EXT2,T5 | SPI2,SPF2
   localparam logic [2:0] SRC_REG [NUM_SRC] = '{
      3'h0, 3'h0, 3'h0,
      3'h1, 3'h1, 3'h1, 3'h1,
      3'h2, 3'h2,
      3'h3, 3'h3, 3'h3, 3'h3,
      3'h4,
      3'h5, 3'h5, 3'h5,
      3'h6, 3'h6, 3'h6, 3'h6,
      3'h7, 3'h7, 3'h7};
   localparam int SRC_POS [NUM_SRC] = '{
      POS_HI, POS_MH, POS_ML,
      POS_HI, POS_MH, POS_ML, POS_LO,
      POS_ML, POS_LO,
      POS_HI, POS_MH, POS_ML, POS_LO,
      POS_LO,
      POS_HI, POS_MH, POS_ML,
      POS_HI, POS_MH, POS_ML, POS_LO,
      POS_ML, POS_LO, POS_LO};
   // Last entry is a spare slot beyond the SPI2 pair, kept at reset
   localparam logic [NUM_SRC-1:0] SRC_USED = 24'h7fffff;

   // ==========================================================
   // Write channel: accept address and data in either order
   logic        aw_held_reg;
   logic [4:0]  aw_addr_reg;
   logic        w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        wr_fire;
   logic        wr_hit;
   logic [2:0]  wr_index;

   assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
   assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
   assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_index      = aw_addr_reg[4:2];
   assign wr_hit        = (aw_addr_reg[1:0] == 2'h0);

   // Capture the write address
   always_ff @(posedge CORE_CLK or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 5'h00;
      end
      else if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= S_AXI_AWADDR;
      end
      else if (wr_fire)
         aw_held_reg <= 1'b0;
   end

   // Capture the write data and strobes
   always_ff @(posedge CORE_CLK or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end
      else if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         w_held_reg <= 1'b1;
         w_data_reg <= S_AXI_WDATA;
         w_strb_reg <= S_AXI_WSTRB;
      end
      else if (wr_fire)
         w_held_reg <= 1'b0;
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge CORE_CLK or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
         bvalid_reg <= 1'b0;
   end

   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP  = bresp_reg;

   // ==========================================================
   // Priority fields, one instance per source
   logic [PRIO_W-1:0] prio [NUM_SRC];

   for (genvar i = 0; i < NUM_SRC; i++)
   begin : g_src
      localparam int P = SRC_POS[i];
      logic          lane_ok;
      logic          f_wr;
      // Both fields of a byte lane follow that lane's strobe
      assign lane_ok = (P >= 8) ? w_strb_reg[1] : w_strb_reg[0];
      // Only mapped field bits are written; all else is dropped
      assign f_wr = wr_fire && wr_hit && SRC_USED[i]
                    && (wr_index == SRC_REG[i]) && lane_ok;

      ipb_field u_field (
         .clk     (CORE_CLK),
         .rst_n   (rst_n_reg),
         .wr_en   (f_wr),
         .wr_data (w_data_reg[P +: PRIO_W]),
         .value   (prio[i])
      );

      // Present level and disable state to the arbiter
      assign PRIO_LEVELS[i*PRIO_W +: PRIO_W] = prio[i];
      assign SRC_ACTIVE[i] = SRC_USED[i] && (prio[i] != 3'h0);
   end

   // ==========================================================
   // Register image: fields placed, every other bit zero
   logic [15:0] reg_image [8];

   always_comb
   begin
      for (int r = 0; r < 8; r++)
         reg_image[r] = 16'h0000;
      for (int s = 0; s < NUM_SRC; s++)
         if (SRC_USED[s])
            reg_image[SRC_REG[s]][SRC_POS[s] +: PRIO_W] = prio[s];
   end

   // ==========================================================
   // Read channel: one read at a time, data from a register
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   assign S_AXI_ARREADY = !rvalid_reg;

   // Address decode and read data capture
   always_ff @(posedge CORE_CLK or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         rvalid_reg <= 1'b1;
         if (S_AXI_ARADDR[1:0] == 2'h0)
         begin
            rdata_reg <= {16'h0000, reg_image[S_AXI_ARADDR[4:2]]};
            rresp_reg <= RESP_OKAY;
         end
         else
         begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_SLVERR;   // Misaligned address
         end
      end
      else if (S_AXI_RREADY)
         rvalid_reg <= 1'b0;
   end

   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA  = rdata_reg;
   assign S_AXI_RRESP  = rresp_reg;

endmodule : ipb_bank

// ==== tb/ipb_bank_sva.sv ====
// Checker of bus answers and field read-back for the priority bank
`timescale 1ns/1ps
module ipb_bank_sva
   import ipb_pkg::*;
(
   // Clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RESET_N,
   // Read and response channels
   input wire logic [4:0]  S_AXI_ARADDR,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   // Arbiter side
   input wire logic [ipb_pkg::NUM_SRC*ipb_pkg::PRIO_W-1:0] PRIO_LEVELS,
   input wire logic [ipb_pkg::NUM_SRC-1:0]                 SRC_ACTIVE
);
   // =====
   // Expected enables; the spare slot never competes
   logic [NUM_SRC-1:0] act_exp;
   always_comb
   begin
      for (int i = 0; i < NUM_SRC; i++)
         act_exp[i] = (PRIO_LEVELS[3*i +: 3] != 3'h0) && (i < NUM_SRC - 1);
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_ar; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
   sequence s_r_wait; S_AXI_RVALID && !S_AXI_RREADY; endsequence
   property p_r_lat; s_ar |=> S_AXI_RVALID; endproperty
   property p_r_stand; s_r_wait |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
   property p_b_stand; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
   endproperty
   property p_upper; S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0; endproperty
   property p_act; SRC_ACTIVE == act_exp; endproperty
   property p_spare; PRIO_LEVELS[71:69] == 3'h4; endproperty
   property p_quiet; !$stable(PRIO_LEVELS) |-> $rose(S_AXI_BVALID); endproperty
   property p_adtx; s_ar ##0 S_AXI_ARADDR == OFS_AD_TX1 |=> S_AXI_RDATA[15:0] ==
      {9'h0, $past(PRIO_LEVELS[23:21]), 1'b0, $past(PRIO_LEVELS[26:24])}; endproperty
   property p_ext1; s_ar ##0 S_AXI_ARADDR == OFS_EXT1 |=>
      S_AXI_RDATA[15:0] == {13'h0, $past(PRIO_LEVELS[41:39])}; endproperty
   a_r_lat: assert property (p_r_lat)
      else $error("read answer late");
   a_r_stand: assert property (p_r_stand)
      else $error("read data not held");
   a_b_stand: assert property (p_b_stand)
      else $error("write response not held");
   a_upper: assert property (p_upper)
      else $error("upper read bits set");
   a_act: assert property (p_act)
      else $error("enable does not follow code");
   a_spare: assert property (p_spare)
      else $error("spare level changed");
   a_quiet: assert property (p_quiet)
      else $error("level moved without write");
   a_adtx: assert property (p_adtx)
      else $error("converter word wrong");
   a_ext1: assert property (p_ext1)
      else $error("line one word wrong");
endmodule : ipb_bank_sva

bind ipb_bank ipb_bank_sva u_sva (.CORE_CLK, .RESET_N, .S_AXI_ARADDR, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_BRESP,
   .S_AXI_BVALID, .S_AXI_BREADY, .PRIO_LEVELS, .SRC_ACTIVE);

// ==== tb/testbench.sv ====
// Self-checking bench of the priority bank against a field model
`timescale 1ns/1ps
module testbench;
   import ipb_pkg::*;
   // =====
   // Stimulus and observed signals
   logic CORE_CLK = 0, RESET_N = 0;
   logic [4:0]  S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
   logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
   logic [3:0]  S_AXI_WSTRB = '0;
   logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
   logic S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   logic S_AXI_RVALID;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   logic [71:0] PRIO_LEVELS;
   logic [23:0] SRC_ACTIVE;
   int error_cnt = 0, checks = 0, mdl [NUM_SRC];
   // Source index at bits 14:12, 10:8, 6:4, 2:0 of each word
   int fmap [8][4] = '{'{0,1,2,-1}, '{3,4,5,6}, '{-1,-1,7,8}, '{9,10,11,12},
      '{-1,-1,-1,13}, '{14,15,16,-1}, '{17,18,19,20}, '{-1,-1,21,22}};
   always #50 CORE_CLK = ~CORE_CLK;
   ipb_bank uut (.CORE_CLK, .RESET_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
      .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
      .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .PRIO_LEVELS, .SRC_ACTIVE);
   // =====
   // Compare and close
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // Model word of one address; misaligned reads as zero
   function automatic logic [31:0] exp_rd(input logic [4:0] a);
      logic [31:0] v;
      v = '0;
      for (int p = 0; p < 4; p++)
         if (a[1:0] == 2'h0 && fmap[a[4:2]][p] >= 0)
            v[12-4*p +: 3] = mdl[fmap[a[4:2]][p]][2:0];
      return v;
   endfunction : exp_rd
   task automatic chk_levels;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         chk(PRIO_LEVELS[3*i +: 3], (i == NUM_SRC-1) ? 3'h4 : mdl[i][2:0]);
         chk(SRC_ACTIVE[i], i < NUM_SRC-1 && mdl[i] != 0);
      end
   endtask : chk_levels
   // =====
   // Bus master; ready is raised after a random stall and held
   task automatic do_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
      bit got;
      int n;
      got = 0;
      n = 0;
      @(posedge CORE_CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_WSTRB <= s;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'($urandom);
      while (!got && n < 40)
      begin
         @(posedge CORE_CLK);
         n++;
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
         got = S_AXI_BVALID && S_AXI_BREADY;
         S_AXI_BREADY <= !got;
      end
      chk(got, 1'b1);
      if (!got) tally_and_finish;
      chk(S_AXI_BRESP, (a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY);
      for (int p = 0; p < 4; p++)
         if (a[1:0] == 2'h0 && fmap[a[4:2]][p] >= 0 && s[p < 2])
            mdl[fmap[a[4:2]][p]] = d[12-4*p +: 3];
      chk_levels();
   endtask : do_wr
   task automatic do_rd(input logic [4:0] a);
      bit got;
      int n;
      got = 0;
      n = 0;
      @(posedge CORE_CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'($urandom);
      while (!got && n < 40)
      begin
         @(posedge CORE_CLK);
         n++;
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
         got = S_AXI_RVALID && S_AXI_RREADY;
         S_AXI_RREADY <= !got;
      end
      chk(got, 1'b1);
      if (!got) tally_and_finish;
      chk(S_AXI_RDATA, exp_rd(a));
      chk(S_AXI_RRESP, (a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY);
   endtask : do_rd
   // =====
   // Reset, every code in every field, random traffic, second reset
   initial
   begin
      logic [4:0] a;
      void'($urandom(32'h1f36dfd3));
      for (int r = 0; r < 2; r++)
      begin
         foreach (mdl[i]) mdl[i] = 4;
         repeat (6) @(posedge CORE_CLK);
         RESET_N <= 1'b1;
         repeat (2) @(posedge CORE_CLK);
         chk_levels();
         for (int w = 0; w < 8; w++) do_rd(5'(w*4));
         for (int c = 0; c < 8 && r == 0; c++)
            for (int w = 0; w < 8; w++)
            begin
               do_wr(5'(w*4), {16'hffff, {4{1'b1, 3'(c)}}}, 4'hf);
               do_rd(5'(w*4));
            end
         repeat (60)
         begin
            a = 5'($urandom);
            if ($urandom % 4) a[1:0] = 2'h0;
            do_wr(a, $urandom, 4'($urandom));
            do_rd(a);
            do_rd(5'($urandom));
         end
         RESET_N <= 1'b0;
      end
      tally_and_finish;
   end
endmodule : testbench
